// ==== design/hcrx_pkg.sv ====
// Package for the per-channel HDLC receive configuration block.
// Assumes a single 10 MHz clock domain and an Avalon-MM register master.
package hcrx_pkg;
  // Register byte offsets
  localparam logic [3:0] ADDR_CONFIG    = 4'h0;
  localparam logic [3:0] ADDR_LIMITS    = 4'h4;
  localparam logic [3:0] ADDR_STATUS    = 4'h8;
  localparam logic [3:0] ADDR_CLEAR     = 4'hC;
  localparam logic [3:0] ADDR_ENABLE    = 4'h0;
  localparam logic [4:0] ADDR_ENABLE_HI = 5'h10;
  localparam logic [4:0] ADDR_STATE     = 5'h14;
  // Configuration word field positions
  localparam int DUP_MASK_BIT   = 5;
  localparam int LINE_MASK_BIT  = 4;
  localparam int LSEL_LO        = 10;
  localparam int LSEL_HI        = 11;
  localparam int PROTO_LO       = 12;
  localparam int PROTO_HI       = 14;
  localparam int LIMIT_W        = 12;
  localparam int LIMIT_TWO_LO   = 16;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMITS_RESET = 32'h0000_0000;
  // Status bit positions
  localparam int EV_DUP   = 0;
  localparam int EV_ABORT = 1;
  localparam int EV_IDLE  = 2;
  localparam int EV_SHORT = 3;
  localparam int EV_LONG  = 4;
  localparam int EV_N     = 5;

  typedef enum logic [4:0] {
    HCRX_TRANSPARENT = 5'h01,
    HCRX_SS7_FCS16   = 5'h02,
    HCRX_HDLC_FCS16  = 5'h04,
    HCRX_HDLC_FCS32  = 5'h08,
    HCRX_RESERVED    = 5'h10
  } hcrx_proto_t;

  localparam logic [2:0] PROTO_CODE_TRANSPARENT = 3'h0;
  localparam logic [2:0] PROTO_CODE_SS7         = 3'h1;
  localparam logic [2:0] PROTO_CODE_FCS16       = 3'h2;
  localparam logic [2:0] PROTO_CODE_FCS32       = 3'h3;
  localparam logic [1:0] LSEL_NONE = 2'h0;
  localparam logic [1:0] LSEL_ONE  = 2'h1;
  localparam logic [1:0] LSEL_TWO  = 2'h2;

  // Receiver-side message report
  typedef struct packed {
    logic               msg_end;
    logic               msg_same;
    logic [13:0]        msg_len;
    logic               abort_seen;
    logic               idle_seen;
    logic               too_short;
  } hcrx_rx_report_t;

  typedef struct packed {
    logic               check_on;
    logic [LIMIT_W-1:0] limit;
  } hcrx_limit_t;
endpackage : hcrx_pkg

// ==== design/hcrx_decode.sv ====
// Decoder of the channel configuration word into protocol and length limit.
// Assumes config and limit words are stable registers on the same clock.
`timescale 1ns/1ps
module hcrx_decode (
  input  wire logic [31:0]          config_word,
  input  wire logic [31:0]          limits_word,
  output hcrx_pkg::hcrx_proto_t     proto,
  output hcrx_pkg::hcrx_limit_t     limit
);
  logic [2:0] code;
  logic [1:0] sel;
  assign code = config_word[hcrx_pkg::PROTO_HI:hcrx_pkg::PROTO_LO];
  assign sel  = config_word[hcrx_pkg::LSEL_HI:hcrx_pkg::LSEL_LO];

  always_comb begin
    unique case (code)
      hcrx_pkg::PROTO_CODE_TRANSPARENT: proto = hcrx_pkg::HCRX_TRANSPARENT;
      hcrx_pkg::PROTO_CODE_SS7:         proto = hcrx_pkg::HCRX_SS7_FCS16;
      hcrx_pkg::PROTO_CODE_FCS16:       proto = hcrx_pkg::HCRX_HDLC_FCS16;
      hcrx_pkg::PROTO_CODE_FCS32:       proto = hcrx_pkg::HCRX_HDLC_FCS32;
      default:                          proto = hcrx_pkg::HCRX_RESERVED;
    endcase
  end

  always_comb begin
    limit = '0;
    unique case (sel)
      hcrx_pkg::LSEL_NONE: limit.check_on = 1'b0;
      hcrx_pkg::LSEL_ONE: begin
        limit.check_on = 1'b1;
        limit.limit    = limits_word[hcrx_pkg::LIMIT_W-1:0];
      end
      hcrx_pkg::LSEL_TWO: begin
        limit.check_on = 1'b1;
        limit.limit    = limits_word[hcrx_pkg::LIMIT_TWO_LO+hcrx_pkg::LIMIT_W-1:
                                     hcrx_pkg::LIMIT_TWO_LO];
      end
      // Code 3 is reserved; treated as no check
      default: limit.check_on = 1'b0;
    endcase
  end
endmodule : hcrx_decode

// ==== design/hcrx_irq.sv ====
// Sticky event status with write-one clear and enable gating.
// Assumes events are one-cycle pulses on the same clock.
`timescale 1ns/1ps
module hcrx_irq #(
  parameter int N = 5
) (
  input  wire logic         clk,
  input  wire logic         resetn,
  input  wire logic [N-1:0] event_pulse,
  input  wire logic [N-1:0] clear_bits,
  input  wire logic [N-1:0] enable_bits,
  output logic      [N-1:0] status,
  output logic              irq
);
  logic [N-1:0] next_status;
  // Set wins over a clear in the same cycle
  always_comb begin
    next_status = (status & ~clear_bits) | event_pulse;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status <= '0;
    end else begin
      status <= next_status;
    end
  end
  assign irq = |(status & enable_bits);
endmodule : hcrx_irq

// ==== design/hcrx_top.sv ====
// Per-channel HDLC receive configuration: masks, protocol and length check.
// Assumes a receiver upstream reports message ends and line-state changes.
// Function
// - SS7 mode, duplicate mask clear: a repeated message raises an event and is dropped.
// - SS7 mode, duplicate mask set: a repeated message raises no event but is still dropped.
// - With the line-state mask clear, changes to abort or idle and short messages raise events.
// - With the line-state mask set, the abort, idle and short-message events are suppressed.
// - A length-select value of 0 disables the maximum length check.
// - A length-select value of 1 uses the first limit as the maximum length.
// - A length-select value of 2 uses the second limit as the maximum length.
//
// The address map and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/1ps
module hcrx_top (
  input  wire logic                      clk,
  input  wire logic                      resetn,
  input  wire logic [4:0]                avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output logic      [31:0]               avs_readdata,
  output logic                           avs_waitrequest,
  input  wire hcrx_pkg::hcrx_rx_report_t rx_report,
  output logic                           msg_discard,
  output logic                           msg_too_long,
  output hcrx_pkg::hcrx_proto_t          proto_mode,
  output logic                           irq
);
  logic [31:0]                    config_word;
  logic [31:0]                    limits_word;
  logic [hcrx_pkg::EV_N-1:0]      enable_bits;
  logic [31:0]                    next_config;
  logic [31:0]                    next_limits;
  logic [hcrx_pkg::EV_N-1:0]      next_enable;
  logic                           done;
  logic                           next_done;
  logic [31:0]                    next_readdata;
  logic                           next_discard;
  logic                           next_too_long;
  logic [hcrx_pkg::EV_N-1:0]      events;
  logic [hcrx_pkg::EV_N-1:0]      clear_bits;
  logic [hcrx_pkg::EV_N-1:0]      status;
  hcrx_pkg::hcrx_proto_t          proto;
  hcrx_pkg::hcrx_limit_t          limit;
  logic                           access;
  logic                           dup_mask;
  logic                           line_mask;
  logic                           is_ss7;
  logic [31:0]                    wmask;

  hcrx_decode u_decode (
    .config_word (config_word),
    .limits_word (limits_word),
    .proto       (proto),
    .limit       (limit)
  );

  hcrx_irq #(
    .N (hcrx_pkg::EV_N)
  ) u_irq (
    .clk         (clk),
    .resetn      (resetn),
    .event_pulse (events),
    .clear_bits  (clear_bits),
    .enable_bits (enable_bits),
    .status      (status),
    .irq         (irq)
  );

  assign dup_mask  = config_word[hcrx_pkg::DUP_MASK_BIT];
  assign line_mask = config_word[hcrx_pkg::LINE_MASK_BIT];
  assign is_ss7    = (proto == hcrx_pkg::HCRX_SS7_FCS16);

  // One wait cycle per access; writes land on the answering edge only
  assign access          = (avs_read | avs_write) & ~done;
  assign avs_waitrequest = (avs_read | avs_write) & ~done;

  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end

  always_comb begin
    next_config = config_word;
    next_limits = limits_word;
    next_enable = enable_bits;
    clear_bits  = '0;
    next_done   = access;
    next_readdata = avs_readdata;
    if (done && avs_write) begin
      unique case (avs_address)
        {1'b0, hcrx_pkg::ADDR_CONFIG}:
          next_config = (config_word & ~wmask) | (avs_writedata & wmask);
        {1'b0, hcrx_pkg::ADDR_LIMITS}:
          next_limits = (limits_word & ~wmask) | (avs_writedata & wmask);
        {1'b0, hcrx_pkg::ADDR_CLEAR}:
          clear_bits = avs_writedata[hcrx_pkg::EV_N-1:0] & wmask[hcrx_pkg::EV_N-1:0];
        hcrx_pkg::ADDR_ENABLE_HI:
          next_enable = (enable_bits & ~wmask[hcrx_pkg::EV_N-1:0]) |
                        (avs_writedata[hcrx_pkg::EV_N-1:0] & wmask[hcrx_pkg::EV_N-1:0]);
        default: ;
      endcase
    end
    if (access && avs_read) begin
      unique case (avs_address)
        {1'b0, hcrx_pkg::ADDR_CONFIG}: next_readdata = config_word;
        {1'b0, hcrx_pkg::ADDR_LIMITS}: next_readdata = limits_word;
        {1'b0, hcrx_pkg::ADDR_STATUS}:
          next_readdata = {{(32-hcrx_pkg::EV_N){1'b0}}, status};
        hcrx_pkg::ADDR_ENABLE_HI:
          next_readdata = {{(32-hcrx_pkg::EV_N){1'b0}}, enable_bits};
        hcrx_pkg::ADDR_STATE:
          next_readdata = {27'h0000000, proto};
        // Unmapped and write-only addresses read zero
        default: next_readdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      config_word  <= hcrx_pkg::CONFIG_RESET;
      limits_word  <= hcrx_pkg::LIMITS_RESET;
      enable_bits  <= '0;
      done         <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      config_word  <= next_config;
      limits_word  <= next_limits;
      enable_bits  <= next_enable;
      done         <= next_done;
      avs_readdata <= next_readdata;
    end
  end

  // Event generation from the receiver report
  always_comb begin
    events = '0;
    events[hcrx_pkg::EV_DUP] = rx_report.msg_end & rx_report.msg_same & is_ss7 & ~dup_mask;
    events[hcrx_pkg::EV_ABORT] = rx_report.abort_seen & ~line_mask;
    events[hcrx_pkg::EV_IDLE]  = rx_report.idle_seen & ~line_mask;
    events[hcrx_pkg::EV_SHORT] = rx_report.too_short & ~line_mask;
    events[hcrx_pkg::EV_LONG]  = next_too_long;
  end

  always_comb begin
    next_discard  = rx_report.msg_end & rx_report.msg_same & is_ss7;
    next_too_long = rx_report.msg_end & limit.check_on &
                    (rx_report.msg_len > {2'b00, limit.limit});
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      msg_discard  <= 1'b0;
      msg_too_long <= 1'b0;
      proto_mode   <= hcrx_pkg::HCRX_TRANSPARENT;
    end else begin
      msg_discard  <= next_discard;
      msg_too_long <= next_too_long;
      proto_mode   <= proto;
    end
  end
endmodule : hcrx_top

// ==== tb/hcrx_rx_model.sv ====
// Stand-in for the serial receiver: emits message and line-state reports.
// Assumes the bench calls send from one thread, one report at a time.
`timescale 1ns/1ps
module hcrx_rx_model (
  input wire logic                  clk,
  output hcrx_pkg::hcrx_rx_report_t rpt
);
  initial rpt = '0;
  // Flags pulse one cycle; the idle length is scrambled so it is never reused
  task automatic send(input hcrx_pkg::hcrx_rx_report_t r);
    @(posedge clk);
    rpt <= r;
    @(posedge clk);
    rpt <= {2'h0, ~r.msg_len, 3'h0};
  endtask : send
endmodule : hcrx_rx_model

// ==== tb/hcrx_checker.sv ====
// Checker of the receive configuration block, seen from its ports.
// Assumes full-word writes and no report within one cycle after a write.
`timescale 1ns/1ps
module hcrx_checker (
  input wire logic                      clk,
  input wire logic                      resetn,
  input wire logic [4:0]                avs_address,
  input wire logic                      avs_write,
  input wire logic [31:0]               avs_writedata,
  input wire logic                      avs_waitrequest,
  input wire hcrx_pkg::hcrx_rx_report_t rx_report,
  input wire logic                      msg_discard,
  input wire logic                      msg_too_long,
  input wire hcrx_pkg::hcrx_proto_t     proto_mode,
  input wire logic                      irq
);
  logic [31:0] cfg;
  logic [31:0] lim;
  logic [4:0]  en;
  // Shadows load on the same edge as the registers; proto_mode lags a cycle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg <= '0;
      lim <= '0;
      en  <= '0;
    end else if (avs_write && !avs_waitrequest) begin
      if (avs_address == 5'h00) cfg <= avs_writedata;
      if (avs_address == 5'h04) lim <= avs_writedata;
      if (avs_address == 5'h10) en <= avs_writedata[4:0];
    end
  end
  wire       ss7 = proto_mode == hcrx_pkg::HCRX_SS7_FCS16;
  wire [1:0] sel = cfg[11:10];
  wire       lng = rx_report.msg_len > (sel == 2'h1 ? lim[11:0] : lim[27:16]);
  wire [4:0] ep  = cfg[14] ? 5'h10 : 5'h01 << cfg[13:12];
  wire       lin = rx_report.abort_seen && en[1] || rx_report.idle_seen && en[2]
                   || rx_report.too_short && en[3];
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_dup;
    rx_report.msg_end && rx_report.msg_same;
  endsequence
  sequence s_quiet;
    !irq && !avs_write && !rx_report.msg_end;
  endsequence
  a_dup_discard: assert property (s_dup ##0 ss7 |=> msg_discard)
    else $error("duplicate not discarded");
  a_dup_other: assert property (s_dup ##0 !ss7 |=> !msg_discard)
    else $error("discard outside signalling mode");
  a_dup_irq: assert property (s_dup ##0 ss7 && !cfg[5] && en[0] |=> irq)
    else $error("duplicate raised no interrupt");
  a_dup_masked: assert property (s_dup ##0 ss7 && cfg[5] && sel == 2'h0 && !irq
    && !avs_write && rx_report[2:0] == 3'h0 |=> !irq)
    else $error("masked duplicate raised interrupt");
  a_line_irq: assert property (lin && !cfg[4] |=> irq)
    else $error("line event raised no interrupt");
  a_line_masked: assert property (s_quiet ##0 cfg[4] |=> !irq)
    else $error("masked line event raised interrupt");
  a_len_off: assert property (rx_report.msg_end && sel[0] == sel[1] |=> !msg_too_long)
    else $error("length checked while disabled");
  a_len_one: assert property (rx_report.msg_end && sel == 2'h1
    |=> msg_too_long == $past(lng))
    else $error("first limit misapplied");
  a_len_two: assert property (rx_report.msg_end && sel == 2'h2
    |=> msg_too_long == $past(lng))
    else $error("second limit misapplied");
  a_proto_map: assert property ($stable(cfg[14:12]) [*3] |-> proto_mode == ep)
    else $error("protocol decode wrong");
endmodule : hcrx_checker

// ==== tb/testbench.sv ====
// Self-checking bench for the receive configuration block.
// Assumes the package is compiled first; the model plays the serial receiver.
`timescale 1ns/1ps
module testbench;
  logic                      clk = 0, resetn = 0, avs_read = 0, avs_write = 0, irq;
  logic [4:0]                avs_address = '0;
  logic [31:0]               avs_writedata = '0, avs_readdata, rd, lm;
  logic                      avs_waitrequest, msg_discard, msg_too_long;
  logic [13:0]               ln;
  hcrx_pkg::hcrx_rx_report_t rx_report;
  hcrx_pkg::hcrx_proto_t     proto_mode;
  int                        fails = 0, cmp_count = 0;
  integer                    seed = 32'h8da19a71;
  always #50 clk = ~clk;
  hcrx_top dut_u (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rx_report(rx_report), .msg_discard(msg_discard), .msg_too_long(msg_too_long),
    .proto_mode(proto_mode), .irq(irq));
  hcrx_rx_model rx_u (.clk(clk), .rpt(rx_report));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) fails++;
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic msg(input hcrx_pkg::hcrx_rx_report_t r);
    rx_u.send(r);
    @(negedge clk);
  endtask : msg
  function automatic logic el(input logic [1:0] s, input logic [31:0] l, input logic [13:0] n);
    return s == 2'h1 ? n > l[11:0] : s == 2'h2 ? n > l[27:16] : 1'b0;
  endfunction : el
  task automatic stop_test;
    if (fails == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    #500000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    chk("reset proto", proto_mode, 5'h01);
    bus(1, 5'h10, 32'h1F);
    for (int c = 0; c < 8; c++) begin
      bus(1, 5'h00, c << 12);
      bus(0, 5'h18, 0);
      chk("unmapped", rd, 0);
      chk("proto", proto_mode, c[2] ? 5'h10 : 5'h01 << c[1:0]);
      bus(0, 5'h14, 0);
      chk("state", rd, c[2] ? 32'h10 : 32'h1 << c[1:0]);
    end
    // Boundary lengths first, then random ones
    for (int i = 0; i < 40; i++) begin
      lm = $random(seed);
      bus(1, 5'h04, lm);
      bus(1, 5'h00, 32'h2030 | (i % 4) << 10);
      ln = (i % 4 == 1) ? lm[11:0] : lm[27:16];
      ln = i < 16 ? ln + i[2] : $random(seed);
      msg('{msg_end: 1'b1, msg_len: ln, default: '0});
      chk("too long", msg_too_long, el(i % 4, lm, ln));
    end
    for (int m = 0; m < 4; m++) begin
      bus(1, 5'h00, 32'h1000 | m << 4);
      bus(1, 5'h0C, 32'h1F);
      msg('{msg_end: 1'b1, msg_same: 1'b1, default: '0});
      chk("discard", msg_discard, 1);
      chk("dup irq", irq, !m[1]);
      for (int k = 0; k < 3; k++) begin
        bus(1, 5'h0C, 32'h1F);
        msg(hcrx_pkg::hcrx_rx_report_t'(19'h1 << k));
        chk("line irq", irq, !m[0]);
        bus(0, 5'h08, 0);
        chk("status", rd[3:1], m[0] ? 0 : 3'h4 >> k);
      end
    end
    bus(1, 5'h00, 32'h2000);
    bus(1, 5'h10, 32'h0);
    msg('{msg_end: 1'b1, msg_same: 1'b1, abort_seen: 1'b1, default: '0});
    chk("fcs16 discard", msg_discard, 0);
    chk("disabled irq", irq, 0);
    bus(1, 5'h10, 32'h2);
    @(negedge clk);
    chk("enabled irq", irq, 1);
    bus(1, 5'h0C, 32'h1F);
    @(negedge clk);
    chk("cleared irq", irq, 0);
    stop_test();
  end
endmodule : testbench
bind hcrx_top hcrx_checker chk_u (.clk(clk), .resetn(resetn), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
  .rx_report(rx_report), .msg_discard(msg_discard), .msg_too_long(msg_too_long),
  .proto_mode(proto_mode), .irq(irq));
